// ===== serial_mode_pkg.sv
/*
  Constants, field layouts and carrier types for the serial port mode configuration block.
  Assumes a 250 MHz system clock and an AHB-Lite register bus with 32-bit data.
*/
package serial_mode_pkg;

  // Register indices; byte address is four times the index, second bank adds the bank offset
  localparam logic [7:0] MODE_INDEX = 8'hf0;
  localparam logic [7:0] IR_OPTIONS_INDEX = 8'hf1;
  localparam logic [7:0] TIMEOUT_INDEX = 8'hf2;
  localparam logic [7:0] STATUS_INDEX = 8'hf3;
  localparam int unsigned BANK_BIT = 10;
  localparam int unsigned INDEX_LSB = 2;

  // Mode register fields
  localparam int unsigned MIDI_BIT = 0;
  localparam int unsigned HIGH_SPEED_BIT = 1;
  localparam int unsigned FREQ_LSB = 2;
  localparam int unsigned FLOAT_BIT = 5;
  localparam int unsigned ALL_SHARE_BIT = 6;
  localparam int unsigned SHARE_BIT = 7;
  localparam logic [7:0] FIRST_MODE_MASK = 8'hcf;
  localparam logic [7:0] SECOND_MODE_MASK = 8'h0f;

  // Infrared option fields
  localparam int unsigned RX_POL_BIT = 0;
  localparam int unsigned TX_POL_BIT = 1;
  localparam int unsigned DUPLEX_BIT = 2;
  localparam int unsigned IR_MODE_LSB = 3;
  localparam logic [7:0] IR_OPTIONS_MASK = 8'h3f;

  // Status fields
  localparam int unsigned STATUS_BLANK_BIT = 0;
  localparam int unsigned STATUS_HOLD_BIT = 1;

  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] IR_OPTIONS_RESET = 8'h02;
  localparam logic [7:0] TIMEOUT_RESET = 8'h03;
  localparam logic FLOAT_RESET = 1'b0;

  // Timing
  localparam int unsigned CLOCK_PERIOD_NS = 4;
  localparam int unsigned STEP_TIME_NS = 100000;
  localparam int unsigned STEP_CYCLES = STEP_TIME_NS / CLOCK_PERIOD_NS;
  localparam int unsigned STEP_COUNT_W = 16;

  localparam int unsigned OTHER_PORTS = 4;

  typedef enum logic [1:0] {
    FREQ_STANDARD = 2'b00,
    FREQ_921K = 2'b01,
    FREQ_1M5 = 2'b10,
    FREQ_RESERVED = 2'b11
  } freq_select_type;

  typedef enum logic [2:0] {
    IR_STANDARD = 3'b000,
    IR_IRDA = 3'b001,
    IR_KEYED_CARRIER = 3'b010,
    IR_RESERVED3 = 3'b011,
    IR_RESERVED4 = 3'b100,
    IR_RESERVED5 = 3'b101,
    IR_RESERVED6 = 3'b110,
    IR_RESERVED7 = 3'b111
  } ir_mode_type;

  typedef struct packed {
    logic midiEnable;
    logic highSpeed;
    freq_select_type freqSelect;
  } port_config_type;

  typedef struct packed {
    logic rxActiveLow;
    logic txActiveLow;
    logic halfDuplex;
    ir_mode_type irMode;
  } ir_config_type;

endpackage

// ===== serial_port_mode_config.sv
/*
  Mode configuration for the first two serial ports: speed and MIDI options, interrupt sharing,
  second port transmit pin float override, infrared polarity, duplex, protocol and half-duplex blanking.
  Assumes an AHB-Lite master on sys_clk, UART logic on sys_clk, and a standby power-on reset pin
  that is asynchronous to sys_clk.
*/
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps

module serial_port_mode_config #(
  parameter int unsigned stepCycles = serial_mode_pkg::STEP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic standbyPorPin,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic firstPortIrq,
  input wire logic secondPortIrq,
  input wire logic [serial_mode_pkg::OTHER_PORTS-1:0] otherPortIrq,
  output logic firstIrqOut,
  output logic secondIrqOut,
  output logic [serial_mode_pkg::OTHER_PORTS-1:0] otherIrqOut,
  output serial_mode_pkg::port_config_type firstConfig,
  output serial_mode_pkg::port_config_type secondConfig,
  output serial_mode_pkg::ir_config_type irConfig,
  input wire logic secondTxData,
  input wire logic secondTxEnable,
  input wire logic secondTxActive,
  input wire logic irRxPin,
  output logic secondTxPinOut,
  output logic secondTxPinOe,
  output logic secondRxData,
  output logic rxBlanked
);
  import serial_mode_pkg::*;

  typedef enum logic [2:0] {
    SLOT_NONE,
    SLOT_FIRST_MODE,
    SLOT_SECOND_MODE,
    SLOT_IR_OPTIONS,
    SLOT_TIMEOUT,
    SLOT_STATUS
  } slot_type;

  typedef enum logic [1:0] {
    BLANK_IDLE,
    BLANK_BUSY,
    BLANK_HOLD
  } blank_state_type;

  function automatic slot_type decodeSlot(input logic [31:0] addr);
    logic [7:0] index;
    index = addr[INDEX_LSB +: 8];
    decodeSlot = SLOT_NONE;
    if (addr[31:BANK_BIT+1] == '0 && addr[1:0] == 2'b00)
    begin
      if (!addr[BANK_BIT] && index == MODE_INDEX)
        decodeSlot = SLOT_FIRST_MODE;
      else if (addr[BANK_BIT] && index == MODE_INDEX)
        decodeSlot = SLOT_SECOND_MODE;
      else if (addr[BANK_BIT] && index == IR_OPTIONS_INDEX)
        decodeSlot = SLOT_IR_OPTIONS;
      else if (addr[BANK_BIT] && index == TIMEOUT_INDEX)
        decodeSlot = SLOT_TIMEOUT;
      else if (addr[BANK_BIT] && index == STATUS_INDEX)
        decodeSlot = SLOT_STATUS;
    end
  endfunction

  // Standby power-on reset comes from another power domain
  logic standbySync1_reg, standbySync2_reg;
  logic standbyRst;

  always_ff @(posedge sys_clk)
  begin
    standbySync1_reg <= standbyPorPin;
    standbySync2_reg <= standbySync1_reg;
  end

  assign standbyRst = standbySync2_reg;

  // Bus slave and register group
  logic wrPend_reg, wrPend_next;
  slot_type wrSlot_reg, wrSlot_next;
  logic [7:0] firstMode_reg, firstMode_next;
  logic [7:0] secondMode_reg, secondMode_next;
  logic [7:0] irOptions_reg, irOptions_next;
  logic [7:0] timeout_reg, timeout_next;
  logic floatOverride_reg, floatOverride_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic addrPhase;
  logic [7:0] statusValue;
  blank_state_type blankState_reg;

  assign addrPhase = hsel && hready && htrans[1];

  always_comb
  begin
    wrPend_next = addrPhase && hwrite;
    wrSlot_next = addrPhase ? decodeSlot(haddr) : SLOT_NONE;
    firstMode_next = firstMode_reg;
    secondMode_next = secondMode_reg;
    irOptions_next = irOptions_reg;
    timeout_next = timeout_reg;
    floatOverride_next = floatOverride_reg;
    if (wrPend_reg)
    begin
      unique case (wrSlot_reg)
        SLOT_FIRST_MODE: firstMode_next = hwdata[7:0] & FIRST_MODE_MASK;
        SLOT_SECOND_MODE:
        begin
          secondMode_next = hwdata[7:0] & SECOND_MODE_MASK;
          floatOverride_next = hwdata[FLOAT_BIT];
        end
        SLOT_IR_OPTIONS: irOptions_next = hwdata[7:0] & IR_OPTIONS_MASK;
        SLOT_TIMEOUT: timeout_next = hwdata[7:0];
        SLOT_STATUS, SLOT_NONE: ;
      endcase
    end
    // Reads see this cycle's write so back-to-back write then read returns the new value
    hrdata_next = 32'h0000_0000;
    if (addrPhase && !hwrite)
    begin
      unique case (decodeSlot(haddr))
        SLOT_FIRST_MODE: hrdata_next = {24'h00_0000, firstMode_next};
        SLOT_SECOND_MODE:
          hrdata_next = {24'h00_0000, secondMode_next | ({7'h00, floatOverride_next} << FLOAT_BIT)};
        SLOT_IR_OPTIONS: hrdata_next = {24'h00_0000, irOptions_next};
        SLOT_TIMEOUT: hrdata_next = {24'h00_0000, timeout_next};
        SLOT_STATUS: hrdata_next = {24'h00_0000, statusValue};
        SLOT_NONE: hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || standbyRst)
    begin
      wrPend_reg <= 1'b0;
      wrSlot_reg <= SLOT_NONE;
      firstMode_reg <= MODE_RESET;
      secondMode_reg <= MODE_RESET;
      irOptions_reg <= IR_OPTIONS_RESET;
      timeout_reg <= TIMEOUT_RESET;
      hrdata_reg <= 32'h0000_0000;
    end
    else
    begin
      wrPend_reg <= wrPend_next;
      wrSlot_reg <= wrSlot_next;
      firstMode_reg <= firstMode_next;
      secondMode_reg <= secondMode_next;
      irOptions_reg <= irOptions_next;
      timeout_reg <= timeout_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // Standby-domain bit survives main power and bus resets
  always_ff @(posedge sys_clk)
  begin
    if (standbyRst)
      floatOverride_reg <= FLOAT_RESET;
    else
      floatOverride_reg <= floatOverride_next;
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  assign firstConfig.midiEnable = firstMode_reg[MIDI_BIT];
  assign firstConfig.highSpeed = firstMode_reg[HIGH_SPEED_BIT];
  assign firstConfig.freqSelect = freq_select_type'(firstMode_reg[FREQ_LSB +: 2]);
  assign secondConfig.midiEnable = secondMode_reg[MIDI_BIT];
  assign secondConfig.highSpeed = secondMode_reg[HIGH_SPEED_BIT];
  assign secondConfig.freqSelect = freq_select_type'(secondMode_reg[FREQ_LSB +: 2]);
  assign irConfig.rxActiveLow = irOptions_reg[RX_POL_BIT];
  assign irConfig.txActiveLow = irOptions_reg[TX_POL_BIT];
  assign irConfig.halfDuplex = irOptions_reg[DUPLEX_BIT];
  assign irConfig.irMode = ir_mode_type'(irOptions_reg[IR_MODE_LSB +: 3]);

  // Interrupt routing
  logic firstIrq_reg, firstIrq_next;
  logic secondIrq_reg, secondIrq_next;
  logic [OTHER_PORTS-1:0] otherIrq_reg, otherIrq_next;
  logic allShare, pairShare, anyIrq;

  assign allShare = firstMode_reg[ALL_SHARE_BIT];
  assign pairShare = firstMode_reg[SHARE_BIT];
  assign anyIrq = firstPortIrq || secondPortIrq || (|otherPortIrq);

  // Sharing drives every line of the group, so a port left with its own line still sees the interrupt
  always_comb
  begin
    firstIrq_next = firstPortIrq;
    secondIrq_next = secondPortIrq;
    otherIrq_next = otherPortIrq;
    if (allShare)
    begin
      firstIrq_next = anyIrq;
      secondIrq_next = anyIrq;
      otherIrq_next = {OTHER_PORTS{anyIrq}};
    end
    else if (pairShare)
    begin
      firstIrq_next = firstPortIrq || secondPortIrq;
      secondIrq_next = firstPortIrq || secondPortIrq;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || standbyRst)
    begin
      firstIrq_reg <= 1'b0;
      secondIrq_reg <= 1'b0;
      otherIrq_reg <= '0;
    end
    else
    begin
      firstIrq_reg <= firstIrq_next;
      secondIrq_reg <= secondIrq_next;
      otherIrq_reg <= otherIrq_next;
    end
  end

  assign firstIrqOut = firstIrq_reg;
  assign secondIrqOut = secondIrq_reg;
  assign otherIrqOut = otherIrq_reg;

  // Half-duplex receive blanking
  logic rxSync1_reg, rxSync2_reg;
  logic irActive, blankEnable, blankNow, stepTick;
  blank_state_type blankState_next;
  logic [STEP_COUNT_W-1:0] prescale_reg, prescale_next;
  logic [7:0] steps_reg, steps_next;
  logic txPin_reg, txPin_next;
  logic txOe_reg, txOe_next;
  logic rxData_reg, rxData_next;

  assign irActive = irConfig.irMode != IR_STANDARD;
  assign blankEnable = irActive && irConfig.halfDuplex;
  assign stepTick = prescale_reg == STEP_COUNT_W'(stepCycles - 1);
  assign blankNow = blankEnable && (secondTxActive || blankState_reg != BLANK_IDLE);
  assign statusValue = {6'h00, blankState_reg == BLANK_HOLD, blankNow};

  always_ff @(posedge sys_clk)
  begin
    rxSync1_reg <= irRxPin;
    rxSync2_reg <= rxSync1_reg;
  end

  always_comb
  begin
    blankState_next = blankState_reg;
    prescale_next = '0;
    steps_next = steps_reg;
    unique case (blankState_reg)
      BLANK_IDLE:
        if (blankEnable && secondTxActive)
          blankState_next = BLANK_BUSY;
      BLANK_BUSY:
        if (!blankEnable)
          blankState_next = BLANK_IDLE;
        else if (!secondTxActive)
        begin
          steps_next = timeout_reg;
          blankState_next = (timeout_reg == 8'h00) ? BLANK_IDLE : BLANK_HOLD;
        end
      BLANK_HOLD:
        if (!blankEnable)
          blankState_next = BLANK_IDLE;
        else if (secondTxActive)
          blankState_next = BLANK_BUSY;
        else if (stepTick)
        begin
          steps_next = steps_reg - 8'h01;
          if (steps_reg == 8'h01)
            blankState_next = BLANK_IDLE;
        end
        else
          prescale_next = prescale_reg + STEP_COUNT_W'(1);
    endcase
    // Idle level is the inactive infrared level, so a blanked receiver sees no pulses
    txPin_next = irActive ? (secondTxData ^ irConfig.txActiveLow) : secondTxData;
    txOe_next = secondTxEnable && !floatOverride_next;
    rxData_next = irActive ? (rxSync2_reg ^ irConfig.rxActiveLow) : rxSync2_reg;
    if (blankNow)
      rxData_next = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || standbyRst)
    begin
      blankState_reg <= BLANK_IDLE;
      prescale_reg <= '0;
      steps_reg <= 8'h00;
      txPin_reg <= 1'b1;
      txOe_reg <= 1'b0;
      rxData_reg <= 1'b0;
    end
    else
    begin
      blankState_reg <= blankState_next;
      prescale_reg <= prescale_next;
      steps_reg <= steps_next;
      txPin_reg <= txPin_next;
      txOe_reg <= txOe_next;
      rxData_reg <= rxData_next;
    end
  end

  assign secondTxPinOut = txPin_reg;
  assign secondTxPinOe = txOe_reg;
  assign secondRxData = rxData_reg;
  assign rxBlanked = blankNow;

  // Checking helpers
  logic [31:0] holdCount_reg;
  logic [7:0] holdSteps_reg;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || standbyRst || blankState_reg != BLANK_HOLD)
    begin
      holdCount_reg <= 32'h0000_0000;
      holdSteps_reg <= steps_next;
    end
    else
      holdCount_reg <= holdCount_reg + 32'h0000_0001;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst || standbyRst);
  a_float_pin_off: assert property (floatOverride_reg |-> !secondTxPinOe)
    else $error("transmit pin driven while float override set");
  a_float_keeps_value: assert property (@(posedge sys_clk) disable iff (standbyRst)
    (sys_rst && !wrPend_reg) |=> $stable(floatOverride_reg))
    else $error("float override changed by a non-standby reset");
  a_standby_reset_values: assert property (@(posedge sys_clk) disable iff (1'b0)
    standbyRst |=> (firstMode_reg == 8'h00 && secondMode_reg == 8'h00 && irOptions_reg == 8'h02
      && timeout_reg == 8'h03 && !floatOverride_reg))
    else $error("registers not at reset values after standby reset");
  a_pair_share_both: assert property ((pairShare && !allShare && (firstPortIrq || secondPortIrq))
    |=> (firstIrqOut && secondIrqOut))
    else $error("shared interrupt did not reach both outputs");
  a_pair_separate: assert property ((!pairShare && !allShare && firstPortIrq && !secondPortIrq)
    |=> (firstIrqOut && !secondIrqOut))
    else $error("separate interrupts leaked between ports");
  a_all_share_every: assert property ((allShare && |otherPortIrq)
    |=> (firstIrqOut && secondIrqOut && &otherIrqOut))
    else $error("all-share interrupt not on every output");
  a_zero_timeout_end: assert property ((blankState_reg == BLANK_BUSY && blankEnable && !secondTxActive
    && timeout_reg == 8'h00) |=> blankState_reg == BLANK_IDLE ##1 !rxBlanked || secondTxActive)
    else $error("zero timeout blanked beyond the transfer");
  a_hold_length: assert property ((blankState_reg == BLANK_HOLD && blankState_next == BLANK_IDLE
    && blankEnable) |-> holdCount_reg + 32'h0000_0001 == 32'(holdSteps_reg) * 32'(stepCycles))
    else $error("turnaround blanking length wrong");
  a_rx_ignored_tx: assert property ((blankEnable && secondTxActive) |=> secondRxData == 1'b0)
    else $error("receive data passed during transmit");
  a_tx_polarity: assert property ((irActive && irConfig.txActiveLow && secondTxEnable)
    |=> secondTxPinOut == !$past(secondTxData))
    else $error("infrared transmit polarity wrong");

endmodule // serial_port_mode_config

// ===== ir_link_model.sv
/*
  Far-side infrared transceiver model: puts a logical bit on the receive pin in its own line
  polarity after a settable lag, and resolves the transmit pin as the module sees it.
  Assumes it shares sys_clk with the block and that the bench picks the line polarity.
*/
`timescale 1ns/100ps

module ir_link_model #(
  parameter int lag = 1
) (
  input wire logic sys_clk,
  input wire logic lineBit,
  input wire logic activeLow,
  input wire logic txPinOut,
  input wire logic txPinOe,
  output logic irRxPin,
  output logic txLine
);
  logic [7:0] pipeReg = 8'h00;
  logic lastTx = 1'b1;

  initial irRxPin = 1'b0;

  // Lag lets the bench make the far side answer promptly or slowly
  always @(posedge sys_clk)
  begin
    pipeReg <= {pipeReg[6:0], lineBit ^ activeLow};
    irRxPin <= pipeReg[lag-1];
    if (txPinOe)
    begin
      lastTx <= txPinOut;
    end
  end

  // A floated pin shows the inverse of the last driven level, so stale data never passes
  assign txLine = txPinOe ? txPinOut : ~lastTx;
endmodule // ir_link_model

// ===== serial_port_mode_config_tb.sv
/*
  Self-checking bench for the serial port mode configuration block with a register model.
  Assumes zero-wait AHB-Lite slave, stepCycles reduced to 4, and the infrared link model.
*/
`timescale 1ns/100ps

module serial_port_mode_config_tb;
  import serial_mode_pkg::*;
  localparam int stepCyc = 4;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic standbyPorPin = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, firstIrqOut, secondIrqOut, irRxPin, txLine;
  logic [31:0] hrdata;
  logic firstPortIrq = 1'b0;
  logic secondPortIrq = 1'b0;
  logic [3:0] otherPortIrq = 4'h0;
  logic [3:0] otherIrqOut;
  port_config_type firstConfig, secondConfig;
  ir_config_type irConfig;
  logic secondTxData = 1'b0;
  logic secondTxEnable = 1'b1;
  logic secondTxActive = 1'b0;
  logic lineBit = 1'b0;
  logic lineLow = 1'b0;
  logic secondTxPinOut, secondTxPinOe, secondRxData, rxBlanked, blankExp;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int n, hold;
  logic [15:0] seed = 16'h2533;
  logic [7:0] v, d;
  logic [31:0] rdv;
  logic [5:0] e;
  logic [7:0] regMdl [0:3] = '{8'h00, 8'h00, 8'h02, 8'h03};
  logic [31:0] addrs [0:3] = '{32'h3c0, 32'h7c0, 32'h7c4, 32'h7c8};
  logic [7:0] masks [0:3] = '{8'hcf, 8'h2f, 8'h3f, 8'hff};
  logic [7:0] shareVal [0:3] = '{8'h00, 8'h80, 8'h40, 8'hc0};
  int bTmo [0:3] = '{2, 0, 3, 1};
  logic [2:0] bMode [0:3] = '{3'd1, 3'd2, 3'd1, 3'd0};
  logic [3:0] bHd = 4'b1011;

  serial_port_mode_config #(.stepCycles(stepCyc)) i_serial_port_mode_config (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .standbyPorPin(standbyPorPin), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .firstPortIrq(firstPortIrq), .secondPortIrq(secondPortIrq),
    .otherPortIrq(otherPortIrq), .firstIrqOut(firstIrqOut), .secondIrqOut(secondIrqOut),
    .otherIrqOut(otherIrqOut), .firstConfig(firstConfig), .secondConfig(secondConfig),
    .irConfig(irConfig), .secondTxData(secondTxData), .secondTxEnable(secondTxEnable),
    .secondTxActive(secondTxActive), .irRxPin(irRxPin), .secondTxPinOut(secondTxPinOut),
    .secondTxPinOe(secondTxPinOe), .secondRxData(secondRxData), .rxBlanked(rxBlanked));

  ir_link_model #(.lag(1)) i_ir_link_model (.sys_clk(sys_clk), .lineBit(lineBit), .activeLow(lineLow),
    .txPinOut(secondTxPinOut), .txPinOe(secondTxPinOe), .irRxPin(irRxPin), .txLine(txLine));

  always #2 sys_clk = ~sys_clk;

  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Called just after a rising edge; returns at the edge that ends the data phase
  task automatic busCycle(input logic [31:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= 2'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "bus response");
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] wd);
    logic [31:0] x;
    busCycle(a, 1'b1, {24'h0, wd}, x);
    for (int i = 0; i < 4; i++)
    begin
      if (addrs[i] == a)
      begin
        regMdl[i] = wd & masks[i];
      end
    end
  endtask

  task automatic rdReg(input int i);
    logic [31:0] x;
    busCycle(addrs[i], 1'b0, 32'h0, x);
    chk(x, {24'h0, regMdl[i]}, "register read");
  endtask

  task automatic cfgChk();
    chk({28'h0, firstConfig}, {28'h0, regMdl[0][0], regMdl[0][1], regMdl[0][3:2]}, "first config");
    chk({28'h0, secondConfig}, {28'h0, regMdl[1][0], regMdl[1][1], regMdl[1][3:2]}, "second config");
    chk({26'h0, irConfig}, {26'h0, regMdl[2][0], regMdl[2][1], regMdl[2][2], regMdl[2][5:3]}, "ir config");
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      $display("BAD %0t run too long", $time);
      complete_run;
    end
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    standbyPorPin <= 1'b0;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) rdReg(i);
    #1 cfgChk();
    @(posedge sys_clk);
    wr(32'h3c4, 8'hff);
    busCycle(32'h3c4, 1'b0, 32'h0, rdv);
    chk(rdv, 32'h0, "unmapped read");
    $display("test reset values done");

    for (int j = 0; j < 8; j++)
    begin
      // Reserved bits are kept at zero as software must
      wr(addrs[0], (rnd() & 8'hc3) | {4'h0, j[1:0], 2'h0});
      wr(addrs[1], (rnd() & 8'h03) | {4'h0, j[1:0], 2'h0});
      wr(addrs[2], (rnd() & 8'h07) | {2'h0, j[2:0], 3'h0});
      wr(addrs[3], rnd());
      for (int i = 0; i < 4; i++) rdReg(i);
      #1 cfgChk();
      @(posedge sys_clk);
    end
    $display("test register fields done");

    for (int m = 0; m < 4; m++)
    begin
      @(posedge sys_clk);
      wr(addrs[0], shareVal[m]);
      repeat (6)
      begin
        @(posedge sys_clk);
        v = rnd();
        {otherPortIrq, secondPortIrq, firstPortIrq} <= v[5:0];
        @(posedge sys_clk);
        e = shareVal[m][6] ? {6{|v[5:0]}} : shareVal[m][7] ? {v[5:2], {2{v[0] | v[1]}}} : v[5:0];
        #1 chk({26'h0, otherIrqOut, secondIrqOut, firstIrqOut}, {26'h0, e}, "irq routing");
      end
    end
    @(posedge sys_clk);
    {otherPortIrq, secondPortIrq, firstPortIrq} <= 6'h00;
    $display("test interrupt sharing done");

    for (int k = 0; k < 6; k++)
    begin
      @(posedge sys_clk);
      wr(addrs[2], {2'h0, 3'(k % 3), 1'b0, k >= 3, k < 3});
      lineLow <= (k < 3);
      repeat (4)
      begin
        v = rnd();
        secondTxData <= v[0];
        lineBit <= v[1];
        repeat (6) @(posedge sys_clk);
        #1 chk({31'h0, secondTxPinOut}, {31'h0, (k % 3 != 0) ? v[0] ^ (k >= 3) : v[0]}, "tx pin");
        chk({31'h0, secondRxData}, {31'h0, (k % 3 != 0) ? v[1] : v[1] ^ (k < 3)}, "rx data");
        chk({31'h0, secondTxPinOe}, 32'h1, "tx enable");
        @(posedge sys_clk);
      end
    end
    $display("test polarity and modes done");

    wr(addrs[1], 8'h20);
    @(posedge sys_clk);
    #1 chk({31'h0, secondTxPinOe}, 32'h0, "float override");
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    regMdl = '{8'h00, 8'h20, 8'h02, 8'h03};
    @(posedge sys_clk);
    for (int i = 0; i < 4; i++) rdReg(i);
    #1 chk({31'h0, secondTxPinOe}, 32'h0, "override after reset");
    @(posedge sys_clk);
    standbyPorPin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    standbyPorPin <= 1'b0;
    regMdl[1] = 8'h00;
    repeat (3) @(posedge sys_clk);
    rdReg(1);
    #1 chk({31'h0, secondTxPinOe}, 32'h1, "override cleared");
    $display("test float override done");

    for (int c = 0; c < 4; c++)
    begin
      @(posedge sys_clk);
      wr(addrs[2], {2'h0, bMode[c], bHd[c], 2'h0});
      wr(addrs[3], 8'(bTmo[c]));
      blankExp = bHd[c] && (bMode[c] != 3'd0);
      hold = blankExp ? bTmo[c] * stepCyc : 0;
      lineLow <= 1'b0;
      lineBit <= 1'b1;
      secondTxActive <= 1'b1;
      repeat (5) @(posedge sys_clk);
      #1 chk({31'h0, rxBlanked}, {31'h0, blankExp}, "blank while sending");
      chk({31'h0, secondRxData}, {31'h0, !blankExp}, "rx while sending");
      @(posedge sys_clk);
      busCycle(32'h7cc, 1'b0, 32'h0, rdv);
      chk(rdv, {31'h0, blankExp}, "status while sending");
      secondTxActive <= 1'b0;
      n = 0;
      repeat (hold + 4)
      begin
        @(posedge sys_clk);
        #1 n += (rxBlanked === 1'b1);
      end
      // One cycle of slack for the edge that loads the hold counter
      chk({31'h0, n >= hold && n <= hold + 1}, 32'h1, "hold length");
    end
    $display("test half duplex blanking done");
    complete_run;
  end
endmodule // serial_port_mode_config_tb
